// file: can_err_map.svh
// Contract
// - Bit 7 summary flag is the OR of all controller interrupt requests.
// - Summary flag is read-only; writes to bit 7 never change it.
// - Bit 4 buffer-overrun flag sets on buffer full, holds until software clears.
// - Bit 1 form-error flag sets on delimiter or end-of-frame violation; software clears.
// - Transmit error counter reads at bits 7-0, read-only, resets to 00h.
// - Receive error counter reads at bits 7-0, read-only, resets to 00h.
`ifndef CAN_ERR_MAP_SVH
`define CAN_ERR_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define GIT_ADDR 8'h9B
`define TEC_ADDR 8'h9C
`define REC_ADDR 8'h9D

// ****************************************
// Status field positions
// ****************************************
`define GIT_SUMMARY_BIT 7
`define GIT_TIMER_BIT 5
`define GIT_BUF_BIT 4
`define GIT_STUFF_BIT 3
`define GIT_CRC_BIT 2
`define GIT_FORM_BIT 1
`define GIT_ACK_BIT 0

// ****************************************
// Reset values and counter steps
// ****************************************
`define GIT_RESET 8'h00
`define CNT_RESET 8'h00
`define CNT_MAX 8'hFF
`define CNT_STEP_BIG 8'h08
`define CNT_STEP_ONE 8'h01
`define RDATA_IDLE 8'h00

`endif

// file: can_err_pkg.sv
package can_err_pkg;
  // Error and status events from the controller core, one-cycle pulses
  typedef struct packed {
    logic stuff_err;
    logic crc_err;
    logic form_err;
    logic ack_err;
    logic buf_full;
    logic timer_wrap;
  } err_evt_s;

  // Error counter step requests
  typedef struct packed {
    logic add8;
    logic add1;
    logic sub1;
  } cnt_step_s;

  typedef logic [7:0] byte_t;
endpackage

// file: can_error_status_counters.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_err_map.svh"
module can_error_status_counters (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // Special function register port
  input wire can_err_pkg::byte_t SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire can_err_pkg::byte_t SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Controller events and counter steps
  input wire can_err_pkg::err_evt_s EVT,
  input wire can_err_pkg::cnt_step_s TX_STEP,
  input wire can_err_pkg::cnt_step_s RX_STEP,
  // Interrupt enables and other controller requests
  input wire logic TIMER_OVF_IRQ_ENABLE,
  input wire logic GEN_ERR_IRQ_ENABLE,
  input wire logic BUF_IRQ_ENABLE,
  input wire logic OTHER_IRQ,
  // Interrupt requests to the interrupt controller
  output logic CAN_IRQ,
  output logic TIMER_IRQ
);
  import can_err_pkg::*;

  // ****************************************
  // Sticky status flags
  // ****************************************
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] set_vec;
  logic git_wr;
  logic summary_r;
  logic summary_nxt;

  assign git_wr = SFR_WR && (SFR_ADDR == `GIT_ADDR);

  always_comb begin
    set_vec = 8'h00;
    set_vec[`GIT_TIMER_BIT] = EVT.timer_wrap;
    set_vec[`GIT_BUF_BIT] = EVT.buf_full;
    set_vec[`GIT_STUFF_BIT] = EVT.stuff_err;
    set_vec[`GIT_CRC_BIT] = EVT.crc_err;
    set_vec[`GIT_FORM_BIT] = EVT.form_err;
    set_vec[`GIT_ACK_BIT] = EVT.ack_err;
    flags_nxt = flags_r;
    // Writing 0 clears, writing 1 keeps; a same-cycle event still wins
    if (git_wr) begin
      flags_nxt = flags_r & SFR_WDATA;
    end
    flags_nxt = flags_nxt | set_vec;
    // Summary and reserved bits are never stored
    flags_nxt[`GIT_SUMMARY_BIT] = 1'b0;
    flags_nxt[6] = 1'b0;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      flags_r <= `GIT_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ****************************************
  // Interrupt requests and summary
  // ****************************************
  logic timer_irq_nxt;
  logic gen_irq_nxt;
  logic buf_irq_nxt;

  assign timer_irq_nxt = flags_nxt[`GIT_TIMER_BIT] && TIMER_OVF_IRQ_ENABLE;
  assign gen_irq_nxt = GEN_ERR_IRQ_ENABLE && (|flags_nxt[`GIT_STUFF_BIT:`GIT_ACK_BIT]);
  assign buf_irq_nxt = BUF_IRQ_ENABLE && flags_nxt[`GIT_BUF_BIT];
  // Computed from next state so the summary bit and the request move together
  assign summary_nxt = timer_irq_nxt || gen_irq_nxt || buf_irq_nxt || OTHER_IRQ;

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      summary_r <= 1'b0;
      CAN_IRQ <= 1'b0;
      TIMER_IRQ <= 1'b0;
    end else begin
      summary_r <= summary_nxt;
      CAN_IRQ <= summary_nxt;
      TIMER_IRQ <= timer_irq_nxt;
    end
  end

  // ****************************************
  // Error counters
  // ****************************************
  // Saturating so a burst of errors cannot wrap a counter back to zero
  function automatic byte_t step_cnt(input byte_t c, input cnt_step_s s);
    byte_t r;
    r = c;
    if (s.add8) begin
      r = (c > (`CNT_MAX - `CNT_STEP_BIG)) ? `CNT_MAX : c + `CNT_STEP_BIG;
    end else if (s.add1) begin
      r = (c == `CNT_MAX) ? c : c + `CNT_STEP_ONE;
    end else if (s.sub1) begin
      r = (c == `CNT_RESET) ? c : c - `CNT_STEP_ONE;
    end
    return r;
  endfunction

  byte_t tx_error_count_r;
  byte_t rx_error_count_r;

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      tx_error_count_r <= `CNT_RESET;
    end else begin
      tx_error_count_r <= step_cnt(tx_error_count_r, TX_STEP);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      rx_error_count_r <= `CNT_RESET;
    end else begin
      rx_error_count_r <= step_cnt(rx_error_count_r, RX_STEP);
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  byte_t rdata_nxt;

  always_comb begin
    rdata_nxt = `RDATA_IDLE;
    unique case (SFR_ADDR)
      `GIT_ADDR: begin
        rdata_nxt = flags_r;
        rdata_nxt[`GIT_SUMMARY_BIT] = summary_r;
      end
      `TEC_ADDR: rdata_nxt = tx_error_count_r;
      `REC_ADDR: rdata_nxt = rx_error_count_r;
      default: rdata_nxt = `RDATA_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      SFR_RDATA <= `RDATA_IDLE;
    end else if (SFR_RD) begin
      SFR_RDATA <= rdata_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // Summary rebuilt from the registered causes, not from summary_nxt
  chk_summary_or: assert property (
    ##1 summary_r == ($past(OTHER_IRQ) || TIMER_IRQ
      || ($past(GEN_ERR_IRQ_ENABLE) && (|flags_r[`GIT_STUFF_BIT:`GIT_ACK_BIT]))
      || ($past(BUF_IRQ_ENABLE) && flags_r[`GIT_BUF_BIT])) && CAN_IRQ == summary_r)
    else $error("summary flag differs from interrupt request");
  chk_summary_ro: assert property (
    git_wr && !summary_nxt |=> !summary_r)
    else $error("write changed summary flag");
  chk_buf_sticky: assert property (
    EVT.buf_full |=> flags_r[`GIT_BUF_BIT])
    else $error("buffer overrun flag not set");
  chk_buf_hold: assert property (
    flags_r[`GIT_BUF_BIT] && !git_wr |=> flags_r[`GIT_BUF_BIT])
    else $error("buffer overrun flag dropped without clear");
  chk_form_set: assert property (
    EVT.form_err && git_wr |=> flags_r[`GIT_FORM_BIT])
    else $error("form error lost against clear");
  // Counters may step in the same cycle as a write, so only quiet cycles are checked
  chk_tx_ro: assert property (
    SFR_WR && SFR_ADDR == `TEC_ADDR && TX_STEP == 3'b000 |=> $stable(tx_error_count_r))
    else $error("transmit counter moved without step");
  chk_rx_ro: assert property (
    SFR_WR && SFR_ADDR == `REC_ADDR && RX_STEP == 3'b000 |=> $stable(rx_error_count_r))
    else $error("receive counter moved without step");
  chk_tx_read: assert property (
    SFR_RD && SFR_ADDR == `TEC_ADDR |=> SFR_RDATA == $past(tx_error_count_r))
    else $error("transmit counter read wrong");
  chk_rx_read: assert property (
    SFR_RD && SFR_ADDR == `REC_ADDR |=> SFR_RDATA == $past(rx_error_count_r))
    else $error("receive counter read wrong");
  chk_timer_irq: assert property (
    EVT.timer_wrap && TIMER_OVF_IRQ_ENABLE |=> TIMER_IRQ && CAN_IRQ)
    else $error("timer overrun did not interrupt");
  chk_timer_clear: assert property (
    git_wr && !SFR_WDATA[`GIT_TIMER_BIT] && !EVT.timer_wrap |=> !TIMER_IRQ)
    else $error("timer interrupt survived clear");
  chk_timer_set: assert property (
    EVT.timer_wrap |=> flags_r[`GIT_TIMER_BIT])
    else $error("timer overrun flag not set");
  chk_form_hold: assert property (
    flags_r[`GIT_FORM_BIT] && !(git_wr && !SFR_WDATA[`GIT_FORM_BIT]) |=> flags_r[`GIT_FORM_BIT])
    else $error("form error flag dropped without clear");
  chk_summary_rd: assert property (
    SFR_RD && SFR_ADDR == `GIT_ADDR |=> SFR_RDATA[`GIT_SUMMARY_BIT] == $past(summary_r))
    else $error("summary flag read wrong");
  chk_resv_zero: assert property (
    SFR_RD && SFR_ADDR == `GIT_ADDR |=> !SFR_RDATA[6])
    else $error("reserved status bit read as one");
  chk_unmapped_read: assert property (
    SFR_RD && SFR_ADDR != `GIT_ADDR && SFR_ADDR != `TEC_ADDR && SFR_ADDR != `REC_ADDR
      |=> SFR_RDATA == `RDATA_IDLE)
    else $error("unmapped read not idle");

  // Main scenarios
  cov_timer_irq: cover property (EVT.timer_wrap && TIMER_OVF_IRQ_ENABLE ##1 TIMER_IRQ);
  cov_buf_irq: cover property (BUF_IRQ_ENABLE && flags_r[`GIT_BUF_BIT] ##1 CAN_IRQ);
  cov_set_vs_clear: cover property (git_wr && EVT.form_err);
  cov_tx_saturate: cover property (tx_error_count_r == `CNT_MAX);
  cov_git_read: cover property (SFR_RD && SFR_ADDR == `GIT_ADDR ##1 SFR_RDATA[7]);
endmodule
`default_nettype wire

// file: can_net_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_net_model (
  // Clock and request
  input wire logic mclk,
  input wire logic fire,
  input wire logic [1:0] lag,
  input wire can_err_pkg::err_evt_s evt_in,
  // Events towards the controller
  output can_err_pkg::err_evt_s evt
);
  import can_err_pkg::*;
  logic [1:0] wait_r = 2'h0;
  logic armed_r = 1'b0;
  // Slow peers report late; each event is a one-cycle pulse
  always @(posedge mclk) begin
    evt <= '0;
    if (fire) begin
      armed_r <= 1'b1;
      wait_r <= lag;
    end else if (armed_r && wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else if (armed_r) begin
      evt <= evt_in;
      armed_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb_can_error_status_counters.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_err_map.svh"
module tb_can_error_status_counters;
  import can_err_pkg::*;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  byte_t addr = 8'h00;
  byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  err_evt_s evt;
  err_evt_s evt_in = '0;
  cnt_step_s tx_step = '0;
  cnt_step_s rx_step = '0;
  logic tim_en = 1'b0;
  logic gen_en = 1'b0;
  logic buf_en = 1'b0;
  logic other = 1'b0;
  logic fire = 1'b0;
  logic [1:0] lag = 2'h0;
  logic can_irq;
  logic timer_irq;
  int miscompares = 0;
  int n_tests = 0;
  always #5 MCLK = ~MCLK;
  can_net_model peer (.mclk(MCLK), .fire(fire), .lag(lag), .evt_in(evt_in), .evt(evt));
  can_error_status_counters uut (.MCLK(MCLK), .RST_B(RST_B), .SFR_ADDR(addr), .SFR_WR(wr),
    .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .EVT(evt), .TX_STEP(tx_step),
    .RX_STEP(rx_step), .TIMER_OVF_IRQ_ENABLE(tim_en), .GEN_ERR_IRQ_ENABLE(gen_en),
    .BUF_IRQ_ENABLE(buf_en), .OTHER_IRQ(other), .CAN_IRQ(can_irq), .TIMER_IRQ(timer_irq));
  // ****
  // Access tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input byte_t a, input byte_t d);
    @(negedge MCLK);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge MCLK);
    wr = 1'b0;
  endtask
  // Data is settled by the falling edge after the read edge
  task automatic rd_reg(input byte_t a, input byte_t exp);
    @(negedge MCLK);
    addr = a;
    rd = 1'b1;
    @(negedge MCLK);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  task automatic peer_evt(input err_evt_s e, input logic [1:0] l);
    @(negedge MCLK);
    evt_in = e;
    lag = l;
    fire = 1'b1;
    @(negedge MCLK);
    fire = 1'b0;
    repeat (5) @(negedge MCLK);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (3) @(negedge MCLK);
    RST_B = 1'b1;
    rd_reg(`TEC_ADDR, 8'h00);
    rd_reg(`REC_ADDR, 8'h00);
    peer_evt(6'h01, 2'h0);
    rd_reg(`GIT_ADDR, 8'h20);
    chk({7'h00, timer_irq}, 8'h00);
    tim_en = 1'b1;
    rd_reg(`GIT_ADDR, 8'hA0);
    chk({6'h00, can_irq, timer_irq}, 8'h03);
    wr_reg(`GIT_ADDR, 8'h80);
    rd_reg(`GIT_ADDR, 8'h00);
    peer_evt(6'h02, 2'h3);
    rd_reg(`GIT_ADDR, 8'h10);
    buf_en = 1'b1;
    rd_reg(`GIT_ADDR, 8'h90);
    wr_reg(`GIT_ADDR, 8'hEF);
    rd_reg(`GIT_ADDR, 8'h00);
    gen_en = 1'b1;
    peer_evt(6'h08, 2'h1);
    wr_reg(`GIT_ADDR, 8'hFF);
    rd_reg(`GIT_ADDR, 8'h82);
    wr_reg(`GIT_ADDR, 8'hFD);
    rd_reg(`GIT_ADDR, 8'h00);
    // Event pulse lands on the clearing write edge; set must win
    @(negedge MCLK);
    evt_in = 6'h08;
    lag = 2'h0;
    fire = 1'b1;
    @(negedge MCLK);
    fire = 1'b0;
    wr_reg(`GIT_ADDR, 8'hFD);
    rd_reg(`GIT_ADDR, 8'h82);
    wr_reg(`GIT_ADDR, 8'hFD);
    rd_reg(`GIT_ADDR, 8'h00);
    other = 1'b1;
    rd_reg(`GIT_ADDR, 8'h80);
    other = 1'b0;
    peer_evt(6'h01, 2'h2);
    chk({6'h00, can_irq, timer_irq}, 8'h03);
    wr_reg(`GIT_ADDR, 8'hDF);
    chk({6'h00, can_irq, timer_irq}, 8'h00);
    @(negedge MCLK);
    tx_step = 3'b100;
    rx_step = 3'b010;
    @(negedge MCLK);
    tx_step = '0;
    rx_step = '0;
    wr_reg(`TEC_ADDR, 8'h55);
    wr_reg(`REC_ADDR, 8'h55);
    rd_reg(`TEC_ADDR, 8'h08);
    rd_reg(8'h9E, 8'h00);
    rd_reg(`REC_ADDR, 8'h01);
    RST_B = 1'b0;
    @(negedge MCLK);
    RST_B = 1'b1;
    rd_reg(`TEC_ADDR, 8'h00);
    rd_reg(`REC_ADDR, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
